// [core/ltd_pkg.sv]
package ltd_pkg;
  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] ADDR_DURATION = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h008;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h00C;
  localparam logic [11:0] ADDR_REMAINING = 12'h010;
  localparam logic [7:0] DURATION_RESET = 8'h00;
  localparam logic [7:0] STATUS_CLEAR = 8'h00;
  // Status bits for locally started tests; bits 1 and 7 unused
  localparam logic [7:0] LOCAL_TEST_MASK = 8'h75;
  localparam int REMOTE_BIT = 3;
  // ---------------------------------------------------------------
  // Interrupt event bits
  // ---------------------------------------------------------------
  localparam int EV_STARTED = 0;
  localparam int EV_EXPIRED = 1;
  localparam int EV_TERMINATED = 2;
  localparam int EV_REFUSED = 3;
  localparam int EV_WIDTH = 4;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int SECOND_S = 1;
  localparam int SECOND_CYCLES = CLK_HZ * SECOND_S;
  typedef enum logic [1:0] {
    LTD_IDLE = 2'b00,
    LTD_LOCAL = 2'b01,
    LTD_REMOTE = 2'b10
  } ltd_state_t;
endpackage

// [core/ltd_timer.sv]
module ltd_timer
  import ltd_pkg::*;
#(
  parameter int SECOND_COUNT = SECOND_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic start_local_test_in,
  input wire logic [7:0] local_test_bit_in,
  input wire logic remote_test_in,
  input wire logic terminate_local_test_cmd_in,
  output logic [7:0] loop_test_status_reg_out,
  output logic test_active_out,
  output logic start_refused_out,
  output logic irq_out
);

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic [7:0] test_duration_reg;
  logic [7:0] loop_test_status_reg;
  logic [7:0] remaining;
  logic [31:0] sec_cnt;
  logic [EV_WIDTH-1:0] irq_status;
  logic [EV_WIDTH-1:0] irq_mask;
  ltd_state_t state;
  logic wr_acc;
  logic known_addr;
  logic start_ok;
  logic tick;
  logic expire;
  logic [EV_WIDTH-1:0] events;
  logic wr_duration;
  logic wr_irq_status;
  logic wr_irq_mask;
  logic rd_setup;
  logic local_bit_ok;

  function automatic logic addr_known(input logic [11:0] a);
    return a == ADDR_DURATION || a == ADDR_STATUS ||
           a == ADDR_IRQ_STATUS || a == ADDR_IRQ_MASK ||
           a == ADDR_REMAINING;
  endfunction

  // A start names exactly one local status bit and nothing else
  function automatic logic local_bit_valid(input logic [7:0] b);
    return $onehot(b & LOCAL_TEST_MASK) &&
           (b & ~LOCAL_TEST_MASK) == STATUS_CLEAR;
  endfunction

  // Read multiplexer, sampled in the setup cycle
  function automatic logic [31:0] read_word(input logic [11:0] a);
    logic [31:0] word;
    unique case (a)
      ADDR_DURATION: word = {24'h000000, test_duration_reg};
      ADDR_STATUS: word = {24'h000000, loop_test_status_reg};
      ADDR_IRQ_STATUS: word = {28'h0000000, irq_status};
      ADDR_IRQ_MASK: word = {28'h0000000, irq_mask};
      ADDR_REMAINING: word = {24'h000000, remaining};
      default: word = 32'h0000_0000;
    endcase
    return word;
  endfunction

  assign known_addr = addr_known(paddr_in);
  assign wr_acc = psel_in && penable_in && pwrite_in && known_addr;
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && !known_addr;
  assign wr_duration = wr_acc && paddr_in == ADDR_DURATION;
  assign wr_irq_status = wr_acc && paddr_in == ADDR_IRQ_STATUS;
  assign wr_irq_mask = wr_acc && paddr_in == ADDR_IRQ_MASK;
  assign rd_setup = psel_in && !penable_in && !pwrite_in;

  // ---------------------------------------------------------------
  // Test control
  // ---------------------------------------------------------------
  // One-hot request on a local status bit only
  assign local_bit_ok = local_bit_valid(local_test_bit_in);
  assign start_ok = start_local_test_in && state == LTD_IDLE &&
                    !terminate_local_test_cmd_in && local_bit_ok;
  assign start_refused_out = start_local_test_in && !start_ok;
  assign tick = sec_cnt == 32'(SECOND_COUNT - 1);
  assign expire = state == LTD_LOCAL && test_duration_reg != 8'h00 &&
                  tick && remaining == 8'h01;
  assign test_active_out = state != LTD_IDLE;
  assign loop_test_status_reg_out = loop_test_status_reg;

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      test_duration_reg <= DURATION_RESET;
    end else if (wr_duration) begin
      test_duration_reg <= pwdata_in[7:0];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      state <= LTD_IDLE;
      loop_test_status_reg <= STATUS_CLEAR;
    end else begin
      unique case (state)
        LTD_IDLE: begin
          if (start_ok) begin
            state <= LTD_LOCAL;
            loop_test_status_reg <= local_test_bit_in;
          end else if (remote_test_in && !terminate_local_test_cmd_in) begin
            state <= LTD_REMOTE;
            loop_test_status_reg <= 8'(1 << REMOTE_BIT);
          end
        end
        LTD_LOCAL: begin
          // Zero duration never expires; only terminate ends it
          if (terminate_local_test_cmd_in || expire) begin
            state <= LTD_IDLE;
            loop_test_status_reg <= STATUS_CLEAR;
          end
        end
        LTD_REMOTE: begin
          // Remote test is not timed by the local duration
          if (terminate_local_test_cmd_in) begin
            loop_test_status_reg <= STATUS_CLEAR;
            state <= LTD_IDLE;
          end else if (!remote_test_in) begin
            state <= LTD_IDLE;
            loop_test_status_reg <= STATUS_CLEAR;
          end
        end
        default: begin
          state <= LTD_IDLE;
          loop_test_status_reg <= STATUS_CLEAR;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // One-second timebase and seconds counter
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in || start_ok || state != LTD_LOCAL || tick) begin
      sec_cnt <= 32'h0000_0000;
    end else begin
      sec_cnt <= sec_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      remaining <= 8'h00;
    end else if (start_ok) begin
      remaining <= test_duration_reg;
    end else if (state == LTD_LOCAL && tick && remaining != 8'h00) begin
      remaining <= remaining - 8'h01;
    end else if (state != LTD_LOCAL) begin
      remaining <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  assign events[EV_STARTED] = start_ok;
  assign events[EV_EXPIRED] = expire;
  assign events[EV_TERMINATED] = terminate_local_test_cmd_in &&
                                 state != LTD_IDLE;
  assign events[EV_REFUSED] = start_refused_out;

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      irq_status <= '0;
    end else if (wr_irq_status) begin
      // Set wins over write-one-to-clear
      irq_status <= (irq_status & ~pwdata_in[EV_WIDTH-1:0]) | events;
    end else begin
      irq_status <= irq_status | events;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      irq_mask <= '0;
    end else if (wr_irq_mask) begin
      irq_mask <= pwdata_in[EV_WIDTH-1:0];
    end
  end

  assign irq_out = |(irq_status & irq_mask);

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_out <= read_word(paddr_in);
    end
  end

endmodule

// [test/loop_test_duration_timer_tb_top.sv]
module loop_test_duration_timer_tb_top import ltd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SC = 10;
  logic clk = '0, rst = '1, psel = '0, pen = '0, pwr = '0, rem = '0, e;
  logic prdy, perr, st, term, refd, irq, act;
  logic [11:0] pa = '0;
  logic [31:0] pwd = '0, prd, r;
  logic [7:0] tb_bits, stat;
  logic [7:0] bits [5] = '{8'h01, 8'h04, 8'h10, 8'h20, 8'h40};
  int mismatches = 0, checks = 0, dur, n;
  always #20 clk = ~clk;
  ltd_timer #(.SECOND_COUNT(SC)) ltd_timer_inst (.sys_clk_in(clk),
    .sys_rst_in(rst), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy),
    .pslverr_out(perr), .start_local_test_in(st), .local_test_bit_in(tb_bits),
    .remote_test_in(rem), .terminate_local_test_cmd_in(term),
    .loop_test_status_reg_out(stat), .test_active_out(act),
    .start_refused_out(refd), .irq_out(irq));
  ltd_cmd_model ltd_cmd_model_inst (.clk_in(clk), .refused_in(refd),
    .start_out(st), .bit_out(tb_bits), .term_out(term));
  task automatic check(input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      mismatches++;
      $display("CHECK FAILED %0t seen %h exp %h", $time, s, x);
    end
  endtask
  task automatic stop_test;
    if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, logic [31:0] d);
    int k;
    psel <= '1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= '1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (prdy !== 1'b1 && k < 20);
    if (prdy !== 1'b1) begin
      mismatches++;
      stop_test;
    end
    r = prd;
    e = perr;
    psel <= '0;
    pen <= '0;
    @(posedge clk);
  endtask
  initial begin
    dur = $urandom(5708) % 3 + 2;
    repeat (4) @(posedge clk);
    rst <= '0;
    @(posedge clk);
    apb(0, ADDR_DURATION, 0);
    check(r, DURATION_RESET);
    apb(1, ADDR_IRQ_MASK, 32'hF);
    apb(1, ADDR_DURATION, dur);
    apb(0, ADDR_DURATION, 0);
    check(r, dur);
    for (int i = 0; i < 5; i++) begin
      ltd_cmd_model_inst.go(bits[i]);
      @(posedge clk);
      check(stat, bits[i]);
      check(irq, 1);
      check(act, 1);
      ltd_cmd_model_inst.go(8'h01);
      check(ltd_cmd_model_inst.ref_seen, 1);
      check(stat, bits[i]);
      apb(0, ADDR_REMAINING, 0);
      check(r, dur);
      if (i % 2) ltd_cmd_model_inst.stop;
      n = 0;
      while (stat !== 8'h00 && n < 99) begin
        @(posedge clk);
        n++;
      end
      if (i % 2) check(n, 1);
      else check(n >= (dur - 1) * SC - 4 && n < 99, 1);
      if (n == 99) stop_test;
      check(act, 0);
      apb(0, ADDR_IRQ_STATUS, 0);
      check(r, i % 2 ? 32'hD : 32'hB);
      apb(1, ADDR_IRQ_STATUS, 32'hF);
      check(irq, 0);
    end
    rem <= '1;
    repeat (3 * SC) @(posedge clk);
    check(stat, 8'h08);
    check(act, 1);
    ltd_cmd_model_inst.stop;
    @(posedge clk);
    check(stat, STATUS_CLEAR);
    rem <= '0;
    apb(1, ADDR_DURATION, 0);
    apb(1, ADDR_IRQ_MASK, 0);
    ltd_cmd_model_inst.go(8'h40);
    repeat (3 * SC) @(posedge clk);
    check(stat, 8'h40);
    check(irq, 0);
    ltd_cmd_model_inst.stop;
    apb(0, 12'h014, 0);
    check(e, 1);
    check(r, 0);
    check(stat, STATUS_CLEAR);
    stop_test;
  end
endmodule

// [test/ltd_cmd_model.sv]
module ltd_cmd_model (
  input wire logic clk_in,
  input wire logic refused_in,
  output logic start_out = 1'b0,
  output logic [7:0] bit_out = 8'h00,
  output logic term_out = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_seen;
  task automatic go(input logic [7:0] b);
    start_out <= 1'b1;
    bit_out <= b;
    @(posedge clk_in);
    ref_seen = refused_in;
    start_out <= 1'b0;
    bit_out <= ~b;
  endtask
  // Zero duration leaves ending the test to this command
  task automatic stop;
    term_out <= 1'b1;
    @(posedge clk_in);
    term_out <= 1'b0;
  endtask
endmodule

// [test/ltd_timer_props.sv]
module ltd_timer_props
  import ltd_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic start_local_test_in,
  input wire logic [7:0] local_test_bit_in,
  input wire logic terminate_local_test_cmd_in,
  input wire logic [7:0] loop_test_status_reg_out,
  input wire logic test_active_out,
  input wire logic start_refused_out
);
  wire logic [7:0] st = loop_test_status_reg_out;
  wire logic tm = terminate_local_test_cmd_in;
  wire logic act = test_active_out;
  wire logic rq = start_local_test_in;
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  sequence s_go;
    rq && !act && !tm && $onehot(local_test_bit_in)
      && (local_test_bit_in & ~LOCAL_TEST_MASK) == 8'h00;
  endsequence
  property p_go; s_go |=> st == $past(local_test_bit_in); endproperty
  a_go: assert property (p_go) else $error("start not shown");
  property p_take; s_go |-> !start_refused_out; endproperty
  a_take: assert property (p_take) else $error("bad refusal");
  property p_one; rq && act |-> start_refused_out; endproperty
  a_one: assert property (p_one) else $error("second start");
  property p_clr; tm |=> st == STATUS_CLEAR; endproperty
  a_clr: assert property (p_clr) else $error("status kept");
  property p_stop; tm |=> !act; endproperty
  a_stop: assert property (p_stop) else $error("test kept");
  property p_bits; !st[1] && !st[7]; endproperty
  a_bits: assert property (p_bits) else $error("unused bit");
  property p_act; st != 8'h00 |-> act; endproperty
  a_act: assert property (p_act) else $error("idle with status");
  property p_rst; $fell(sys_rst_in) |-> st == 8'h00 && !act; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
endmodule
bind ltd_timer ltd_timer_props ltd_timer_props_inst (
  .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
  .start_local_test_in(start_local_test_in),
  .local_test_bit_in(local_test_bit_in),
  .terminate_local_test_cmd_in(terminate_local_test_cmd_in),
  .loop_test_status_reg_out(loop_test_status_reg_out),
  .test_active_out(test_active_out), .start_refused_out(start_refused_out));
